// file: logic/park_arb_defs.svh
`ifndef PARK_ARB_DEFS_SVH
`define PARK_ARB_DEFS_SVH

// register byte addresses (offsets chosen, aligned words)
`define ADDR_BUS_PARK_CONTROL 8'h00
`define ADDR_ARB_STATUS 8'h04
// control field positions
`define PARK_HI 7
`define PARK_LO 6
`define BIT_INTERNAL_ARB 5
`define BIT_EXTERNAL_ARB 4
`define BIT_DATA_VIS 3
`define BIT_COUNT_WIDTH 0
// writable bits of the control register; bits 2..1 stay zero
`define PARK_CTRL_MASK 8'hF9
`define PARK_CTRL_RESET 8'h00
// park field encodings
`define PARK_ROUND_ROBIN 2'h0
`define PARK_ON_CORE 2'h1
`define PARK_ON_DMA 2'h2
`define PARK_ON_CURRENT 2'h3
// dma bandwidth setting at maximum
`define DMA_BW_MAX 3'h0

`endif

// file: logic/park_arb_pkg.sv
package park_arb_pkg;
    typedef enum logic [1:0] {
        OWN_NONE,
        OWN_CORE,
        OWN_DMA,
        OWN_EXT
    } owner_t;
endpackage : park_arb_pkg

// file: logic/arb_req_if.sv
`timescale 1ns/1ps
// requests and cycle framing passed from the top to the decision module
interface arb_req_if;
    logic core_req;
    logic dma_req;
    logic ext_req;
    logic cycle_busy;
    logic [2:0] dma_bandwidth_setting;
    logic [1:0] park;
    logic internal_arb_enable;
    logic bus_grant_negated;
    modport top (output core_req, dma_req, ext_req, cycle_busy, dma_bandwidth_setting,
        park, internal_arb_enable, bus_grant_negated);
    modport arb (input core_req, dma_req, ext_req, cycle_busy, dma_bandwidth_setting,
        park, internal_arb_enable, bus_grant_negated);
endinterface : arb_req_if

// file: logic/park_arb_core.sv
`timescale 1ns/1ps
`include "park_arb_defs.svh"
// ownership decision; owner changes only when no cycle is in flight
module park_arb_core (
    input wire logic mclk,
    input wire logic resetn,
    arb_req_if.arb rq,
    output park_arb_pkg::owner_t owner
);
    import park_arb_pkg::*;

    owner_t owner_r;
    owner_t owner_nxt;
    owner_t last_int_r;
    owner_t last_int_nxt;
    logic ext_done_r;
    logic ext_done_nxt;
    logic dma_first;

    assign owner = owner_r;

    always_comb begin
        owner_nxt = owner_r;
        last_int_nxt = last_int_r;
        ext_done_nxt = ext_done_r;
        dma_first = 1'b0;
        if (!rq.cycle_busy) begin
            if (rq.internal_arb_enable && rq.bus_grant_negated && rq.ext_req) begin
                owner_nxt = OWN_EXT;
            end else if (ext_done_r && rq.core_req) begin
                owner_nxt = OWN_CORE;
            end else if (rq.dma_req && rq.dma_bandwidth_setting == `DMA_BW_MAX) begin
                owner_nxt = OWN_DMA;
            end else begin
                case (rq.park)
                    `PARK_ROUND_ROBIN: dma_first = (last_int_r == OWN_CORE);
                    `PARK_ON_CORE: dma_first = 1'b0;
                    `PARK_ON_DMA: dma_first = 1'b1;
                    `PARK_ON_CURRENT: dma_first = (last_int_r == OWN_DMA);
                    default: dma_first = 1'b0;
                endcase
                if (rq.core_req && rq.dma_req) begin
                    owner_nxt = dma_first ? OWN_DMA : OWN_CORE;
                end else if (rq.core_req) begin
                    owner_nxt = OWN_CORE;
                end else if (rq.dma_req) begin
                    owner_nxt = OWN_DMA;
                end else begin
                    owner_nxt = OWN_NONE;
                end
            end
            if (owner_nxt == OWN_EXT) begin
                ext_done_nxt = 1'b1;
            end else if (owner_nxt != OWN_NONE) begin
                ext_done_nxt = 1'b0;
            end
            if (owner_nxt == OWN_CORE || owner_nxt == OWN_DMA) begin
                last_int_nxt = owner_nxt;
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            owner_r <= OWN_NONE;
            last_int_r <= OWN_DMA;
            ext_done_r <= 1'b0;
        end else begin
            owner_r <= owner_nxt;
            last_int_r <= last_int_nxt;
            ext_done_r <= ext_done_nxt;
        end
    end
endmodule : park_arb_core

// file: logic/internal_bus_park_arbiter.sv
//==========================================================
// Operation
// - park field selects one of four schemes
// - bit 5 enables external master arbitration
// - maximum dma bandwidth beats core, except core right after an external master
// - negated grant gives external master priority
// - bit 4 enables register space externally
// - base address register is core only
// - bit 3 drives register data outside
// - data visibility needs bit 4 too
// - bit 0 selects 16 or 24 bit counters
// - round robin alternates core and dma
// - core wins first after reset
// - park on core: dma only when core idle or at maximum bandwidth
// - current master keeps bus while needed
`timescale 1ns/1ps
`include "park_arb_defs.svh"
module internal_bus_park_arbiter (
    input wire logic mclk,
    input wire logic resetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // requesters
    input wire logic core_req,
    input wire logic dma_req,
    input wire logic ext_req,
    input wire logic cycle_busy,
    input wire logic [2:0] dma_bandwidth_setting,
    input wire logic external_bus_grant_in_n,
    // access to the module base address register, by requester
    input wire logic base_reg_access,
    // grants and controls
    output logic core_grant,
    output logic dma_grant,
    output logic ext_grant,
    output logic base_reg_allow,
    output logic reg_space_external,
    output logic register_data_visibility,
    output logic dma_count_width_select
);
    import park_arb_pkg::*;

    //==========================================================
    // pin synchroniser for the grant pin, three stages
    logic [2:0] bg_sync_r;
    logic [2:0] bg_sync_nxt;
    logic bg_n_r;
    logic bg_n_nxt;

    always_comb begin
        bg_sync_nxt = {bg_sync_r[1:0], external_bus_grant_in_n};
        bg_n_nxt = bg_n_r;
        // stage 0 feeds only stage 1; stages 1 and 2 must agree
        if (bg_sync_r[1] == bg_sync_r[2]) begin
            bg_n_nxt = bg_sync_r[2];
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            // zero is an asserted grant, the level of a pin tied low, so no false negation
            bg_sync_r <= 3'h0;
            bg_n_r <= 1'b0;
        end else begin
            bg_sync_r <= bg_sync_nxt;
            bg_n_r <= bg_n_nxt;
        end
    end

    //==========================================================
    // ahb-lite register slave, zero wait states
    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    logic wr_pend_r;
    logic wr_pend_nxt;
    logic [7:0] wr_addr_r;
    logic [7:0] wr_addr_nxt;
    logic [31:0] hrdata_r;
    logic [31:0] hrdata_nxt;
    logic addr_phase;
    owner_t owner;
    logic [31:0] status_word;

    assign addr_phase = hsel && hready && htrans[1];
    // bit 3 is the synchronised pin, the level the arbiter acts on
    assign status_word = {28'h0000000, bg_n_r, ext_grant, dma_grant, core_grant};

    always_comb begin
        ctrl_nxt = ctrl_r;
        // write data trails its address by a cycle, so the address is kept for it
        wr_pend_nxt = addr_phase && hwrite;
        wr_addr_nxt = haddr;
        hrdata_nxt = hrdata_r;
        if (wr_pend_r && wr_addr_r == `ADDR_BUS_PARK_CONTROL) begin
            // reserved bits 2..1 are masked so they read back zero
            ctrl_nxt = hwdata[7:0] & `PARK_CTRL_MASK;
        end
        if (addr_phase && !hwrite) begin
            case (haddr)
                `ADDR_BUS_PARK_CONTROL: hrdata_nxt = {24'h000000, ctrl_r};
                `ADDR_ARB_STATUS: hrdata_nxt = status_word;
                default: hrdata_nxt = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ctrl_r <= `PARK_CTRL_RESET;
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata_r <= 32'h00000000;
        end else begin
            ctrl_r <= ctrl_nxt;
            wr_pend_r <= wr_pend_nxt;
            wr_addr_r <= wr_addr_nxt;
            hrdata_r <= hrdata_nxt;
        end
    end

    assign hrdata = hrdata_r;

    //==========================================================
    // bus response; the slave never stretches a transfer or errors,
    // but the pins still come from flip-flops like every other output
    logic hreadyout_r;
    logic hreadyout_nxt;
    logic hresp_r;
    logic hresp_nxt;

    always_comb begin
        hreadyout_nxt = 1'b1;
        hresp_nxt = 1'b0;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            // ready during reset so a master never sees a stuck bus
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
        end else begin
            hreadyout_r <= hreadyout_nxt;
            hresp_r <= hresp_nxt;
        end
    end

    assign hreadyout = hreadyout_r;
    assign hresp = hresp_r;

    //==========================================================
    // arbitration
    // two edges from request to grant pin: owner register, then output register
    arb_req_if rq ();

    assign rq.core_req = core_req;
    assign rq.dma_req = dma_req;
    assign rq.ext_req = ext_req;
    assign rq.cycle_busy = cycle_busy;
    assign rq.dma_bandwidth_setting = dma_bandwidth_setting;
    assign rq.park = ctrl_r[`PARK_HI:`PARK_LO];
    // with bit 5 clear the grant pin is ignored and external masters never win
    assign rq.internal_arb_enable = ctrl_r[`BIT_INTERNAL_ARB];
    assign rq.bus_grant_negated = bg_n_r;

    park_arb_core u_core (
        .mclk(mclk),
        .resetn(resetn),
        .rq(rq),
        .owner(owner)
    );

    //==========================================================
    // registered outputs; owner decoded to one-hot so one grant at most
    logic [6:0] out_r;
    logic [6:0] out_nxt;

    logic own_core;
    logic own_dma;
    logic own_ext;

    // base_reg_allow uses the owner, not the grant pin, so both move together
    assign own_core = (owner == OWN_CORE);
    assign own_dma = (owner == OWN_DMA);
    assign own_ext = (owner == OWN_EXT);

    always_comb begin
        out_nxt[0] = own_core;
        out_nxt[1] = own_dma;
        out_nxt[2] = own_ext;
        // only the core may touch the base address register
        out_nxt[3] = base_reg_access && own_core;
        out_nxt[4] = ctrl_r[`BIT_EXTERNAL_ARB];
        out_nxt[5] = ctrl_r[`BIT_DATA_VIS] && ctrl_r[`BIT_EXTERNAL_ARB];
        out_nxt[6] = ctrl_r[`BIT_COUNT_WIDTH];
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            out_r <= 7'h00;
        end else begin
            out_r <= out_nxt;
        end
    end

    assign core_grant = out_r[0];
    assign dma_grant = out_r[1];
    assign ext_grant = out_r[2];
    assign base_reg_allow = out_r[3];
    assign reg_space_external = out_r[4];
    assign register_data_visibility = out_r[5];
    assign dma_count_width_select = out_r[6];
endmodule : internal_bus_park_arbiter

// file: sim/park_arb_chk.sv
`timescale 1ns/1ps
//==========================================
// grant and control checks
module park_arb_chk (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic core_req,
    input wire logic dma_req,
    input wire logic ext_req,
    input wire logic cycle_busy,
    input wire logic external_bus_grant_in_n,
    input wire logic base_reg_access,
    input wire logic core_grant,
    input wire logic dma_grant,
    input wire logic ext_grant,
    input wire logic base_reg_allow,
    input wire logic reg_space_external,
    input wire logic register_data_visibility
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // requests reach the grant pins two edges later; base_reg_access one edge later
    chk_one_grant: assert property ($onehot0({core_grant, dma_grant, ext_grant}))
        else $error("two grants");
    chk_frozen_busy: assert property ($past(cycle_busy, 2) |->
        $stable({core_grant, dma_grant, ext_grant}))
        else $error("grant moved in a cycle");
    chk_vis_ext: assert property (register_data_visibility |-> reg_space_external)
        else $error("visibility without bit4");
    chk_base_core: assert property (base_reg_allow |->
        core_grant && $past(base_reg_access, 1))
        else $error("base register opened wrongly");
    chk_core_req: assert property ($rose(core_grant) |-> $past(core_req, 2))
        else $error("core grant unasked");
    chk_dma_req: assert property ($rose(dma_grant) |-> $past(dma_req, 2))
        else $error("dma grant unasked");
    // the grant pin passes four flip-flops first, three stages and the filter; it holds each level two cycles or more
    chk_ext_req: assert property ($rose(ext_grant) |->
        $past(ext_req, 2) && $past(external_bus_grant_in_n, 6))
        else $error("ext grant unasked");
    chk_core_idle: assert property (!$past(core_req, 2) && !$past(cycle_busy, 2) |->
        !core_grant)
        else $error("core kept idle bus");
    cover property ($rose(dma_grant));
    cover property (ext_grant);
    cover property (base_reg_allow);
    cover property ($fell(core_grant) ##[1:4] dma_grant);
endmodule : park_arb_chk

bind internal_bus_park_arbiter park_arb_chk u_chk (.mclk, .resetn, .core_req, .dma_req,
    .ext_req, .cycle_busy, .external_bus_grant_in_n, .base_reg_access, .core_grant,
    .dma_grant, .ext_grant, .base_reg_allow, .reg_space_external, .register_data_visibility);

// file: sim/req_partner.sv
`timescale 1ns/1ps
//==========================================
// bus cycle framing of the granted master
module req_partner (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [2:0] gnt,
    input wire logic slow,
    output logic cycle_busy
);
    logic [2:0] gp_r;
    logic b1_r;
    // a fresh grant runs one cycle, stretched by a clock when slow
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            {gp_r, b1_r, cycle_busy} <= 5'h00;
        end else begin
            gp_r <= gnt;
            b1_r <= gnt != gp_r && gnt != 3'h0;
            cycle_busy <= (gnt != gp_r && gnt != 3'h0) || (b1_r && slow);
        end
    end
endmodule : req_partner

// file: sim/tb_internal_bus_park_arbiter.sv
`timescale 1ns/1ps
//==========================================
// bench
module tb_internal_bus_park_arbiter;
    logic mclk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, pin_n = 1'b0, acc = 1'b0;
    logic slow = 1'b0, hreadyout, hresp, busy, allow, rse, vis, wsel;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [2:0] bw = 3'h1, req = 3'h0;
    wire [2:0] gnt;
    logic [31:0] hwdata = 32'h0, hrdata, rd;
    int n_fail = 0, checks = 0;
    initial forever #2.5 mclk = ~mclk;
    internal_bus_park_arbiter DUT (.mclk, .resetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .core_req(req[0]), .dma_req(req[1]), .ext_req(req[2]), .cycle_busy(busy),
        .dma_bandwidth_setting(bw), .external_bus_grant_in_n(pin_n), .base_reg_access(acc),
        .core_grant(gnt[0]), .dma_grant(gnt[1]), .ext_grant(gnt[2]), .base_reg_allow(allow),
        .reg_space_external(rse), .register_data_visibility(vis),
        .dma_count_width_select(wsel));
    req_partner u_far (.mclk, .resetn, .gnt, .slow, .cycle_busy(busy));
    task finish_test;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test
    task chk(input string nm, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task rdy;
        int i;
        for (i = 0; i < 20 && hreadyout !== 1'b1; i++) @(posedge mclk);
        if (i == 20) begin
            n_fail++;
            finish_test();
        end
    endtask : rdy
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        {hsel, hwrite, haddr, htrans} <= {1'b1, wr, a, 2'h2};
        @(posedge mclk);
        rdy();
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
        @(posedge mclk);
        rdy();
        rd = hrdata;
    endtask : ahb
    // control value, requests, bandwidth, expected grants once settled
    task scen(input logic [7:0] c, input logic [2:0] r, b, e);
        ahb(1'b1, 8'h00, {24'h0, c});
        {req, bw, pin_n, slow, acc} <= {r, b, r[2], 1'($urandom), 1'($urandom)};
        repeat (12) @(posedge mclk);
        @(negedge mclk);
        chk("grants", 32'(gnt), 32'(e));
        chk("base_allow", 32'(allow), 32'(e[0] & acc));
        @(posedge mclk);
        ahb(1'b0, 8'h04, 32'h0);
        chk("status", rd, 32'({r[2], e}));
        $display("test ctl %h req %b done", c, r);
    endtask : scen
    initial begin
        logic [7:0] c;
        logic [2:0] seen;
        int i;
        void'($urandom(32'h49CF));
        repeat (16) @(posedge mclk);
        {resetn, acc} <= 2'h3;
        ahb(1'b0, 8'h00, 32'h0);
        chk("ctl_reset", rd, 32'h0);
        ahb(1'b0, 8'h08, 32'h0);
        chk("unmapped", rd, 32'h0);
        $display("test reset values done");
        req <= 3'h3;
        for (i = 0; i < 20 && gnt === 3'h0; i++) @(negedge mclk);
        chk("first_grant", 32'(gnt), 32'h1);
        seen = 3'h0;
        repeat (40) begin
            @(negedge mclk);
            seen = seen | gnt;
        end
        chk("alternation", 32'(seen), 32'h3);
        $display("test round robin done");
        @(posedge mclk);
        req <= 3'h0;
        // first value sets bit 3 without bit4, so visibility must stay off
        for (i = 0; i < 6; i++) begin
            c = (i == 0) ? 8'h08 : 8'($urandom);
            ahb(1'b1, 8'h00, {24'h0, c});
            @(posedge mclk);
            @(negedge mclk);
            chk("ext_space", 32'(rse), 32'(c[4]));
            chk("visibility", 32'(vis), 32'(c[3] & c[4]));
            chk("count_width", 32'(wsel), 32'(c[0]));
            @(posedge mclk);
            ahb(1'b0, 8'h00, 32'h0);
            chk("control", rd, {24'h0, c & 8'hF9});
            chk("response", 32'(hresp), 32'h0);
            $display("test ctl %h done", c);
        end
        scen(8'h00, 3'h0, 3'h1, 3'h0);
        scen(8'h40, 3'h3, 3'h1, 3'h1);
        scen(8'h80, 3'h3, 3'h1, 3'h2);
        scen(8'hC0, 3'h2, 3'h1, 3'h2);
        scen(8'hC0, 3'h3, 3'h1, 3'h2);
        scen(8'h40, 3'h3, 3'h0, 3'h2);
        scen(8'h60, 3'h7, 3'h1, 3'h4);
        scen(8'h40, 3'h7, 3'h1, 3'h1);
        // second reset in mid-run: control and round-robin history start over
        resetn <= 1'b0;
        repeat (4) @(posedge mclk);
        {resetn, req, pin_n} <= {1'b1, 3'h3, 1'b0};
        for (i = 0; i < 20 && gnt === 3'h0; i++) @(negedge mclk);
        chk("reset_grant", 32'(gnt), 32'h1);
        @(posedge mclk);
        ahb(1'b0, 8'h00, 32'h0);
        chk("reset_ctl", rd, 32'h0);
        $display("test mid-run reset done");
        finish_test();
    end
endmodule : tb_internal_bus_park_arbiter
